// ### dv/host_bus.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus (
  // Register port
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Released lines invert, so a stale value never matches by luck
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clock);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rd_data;
  endtask
endmodule // host_bus
`default_nettype wire

// ### dv/sequence_fault_status_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
module sequence_fault_status_bank_test;
  logic clock, rst_n, ce, run_pin, sleep_pin, done, wr_en, rd_en;
  logic [5:0][7:0] rec, expc;
  logic [5:0] en;
  logic [7:0] addr, wdata, rdata, rv;
  logic [3:0][5:0] model;
  wire logic [3:0][5:0] flag;
  logic [31:0] lfsr = 32'h02820624;
  logic [31:0] r;
  int mismatches = 0;
  int cmp_count = 0;
  int k;
  logic [7:0] amap [4] = '{seq_fault_pkg::ADDR_POWER_ON, seq_fault_pkg::ADDR_POWER_OFF,
    seq_fault_pkg::ADDR_SLEEP_EXIT, seq_fault_pkg::ADDR_SLEEP_ENTRY};
  int order [4] = '{0, 2, 3, 1};

  sequence_fault_status_bank i_dut (.clock(clock), .rst_n(rst_n), .ce(ce),
    .run_request_pin(run_pin), .sleep_request_pin(sleep_pin), .sequence_done(done),
    .power_on_recorded_count(rec), .power_on_expected_count(expc),
    .power_off_recorded_count(rec), .power_off_expected_count(expc),
    .sleep_exit_recorded_count(rec), .sleep_exit_expected_count(expc),
    .sleep_entry_recorded_count(rec), .sleep_entry_expected_count(expc),
    .power_on_fault_enable(en), .power_off_fault_enable(en),
    .sleep_exit_fault_enable(en), .sleep_entry_fault_enable(en),
    .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wdata), .reg_rd_en(rd_en),
    .reg_rd_data(rdata), .power_on_fault_flag(flag[0]), .power_off_fault_flag(flag[1]),
    .sleep_exit_fault_flag(flag[2]), .sleep_entry_fault_flag(flag[3]));
  host_bus i_host (.clock(clock), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wdata), .reg_rd_en(rd_en), .reg_rd_data(rdata));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One sequence of kind s; bad marks channels whose counts disagree
  task automatic run_seq(input int s, input logic [5:0] bad);
    @(negedge clock);
    en = 6'(rnd());
    for (int c = 0; c < 6; c++) begin
      rec[c] = 8'(rnd());
      expc[c] = rec[c] ^ 8'(bad[c]);
    end
    case (s)
      0: run_pin = 1'b1;
      2: sleep_pin = 1'b1;
      3: sleep_pin = 1'b0;
      default: run_pin = 1'b0;
    endcase
    repeat (2) @(negedge clock);
    done = 1'b1;
    model[s] = model[s] | (bad & en);
    @(negedge clock);
    done = 1'b0;
    for (int c = 0; c < 4; c++) chk({2'h0, flag[c]}, {2'h0, model[c]});
  endtask
  task automatic read_all();
    for (int c = 0; c < 4; c++) begin
      i_host.rd(amap[c], rv);
      chk(rv, {2'h0, model[c]});
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #100us;
    mismatches++;
    print_verdict();
  end
  initial begin
    {run_pin, sleep_pin, done, rst_n} = 4'h0;
    ce = 1'b1;
    rec = '0;
    expc = '0;
    en = 6'h00;
    model = '0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    read_all();
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      k = order[i % 4];
      run_seq(k, i < 4 ? 6'h3F : (i < 8 ? 6'h00 : r[13:8]));
      read_all();
      r = rnd();
      i_host.wr(amap[r[9:8]], r[7:0]);
      model[r[9:8]] = model[r[9:8]] & ~r[5:0];
    end
    read_all();
    i_host.wr(8'h1B, 8'hFF);
    i_host.rd(8'h1B, rv);
    chk(rv, 8'h00);
    run_seq(0, 6'h3F);
    // Enable low: a clearing write must not touch the flags
    @(negedge clock);
    ce = 1'b0;
    i_host.wr(amap[0], 8'hFF);
    @(negedge clock);
    ce = 1'b1;
    read_all();
    // Reset in mid-run with run still high
    rst_n = 1'b0;
    model = '0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    read_all();
    for (int c = 0; c < 4; c++) chk({2'h0, flag[c]}, 8'h00);
    for (int c = 0; c < 4; c++) i_host.wr(amap[c], 8'hFF);
    model = '0;
    read_all();
    print_verdict();
  end
endmodule // sequence_fault_status_bank_test
`default_nettype wire

// ### rtl/seq_check_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seq_check_if;
  // One-hot strobe, index by sequence kind
  logic [3:0] check;
  modport src (output check);
  modport dst (input check);
endinterface
`default_nettype wire

// ### rtl/seq_fault_pkg.sv
// Operation
// - Power-on mismatch sets channel power-on flag
// - Power-off mismatch sets channel power-off flag
// - Sleep-exit mismatch sets channel sleep-exit flag
// - Sleep-entry mismatch sets channel sleep-entry flag
// - Run rise starts power-on, fall power-off
// - Sleep falling edge starts sleep entry
// - Flags stay set after fault disappears
// - Writing one clears flag, zero keeps
// - Cleared flag sets again on next mismatch
// - One means fault; disabled channel never sets
// - Top two bits of each register reserved
`default_nettype none
package seq_fault_pkg;
  localparam int unsigned NUM_CH = 6;
  localparam int unsigned NUM_SEQ = 4;
  localparam int unsigned SEQ_ON = 0;
  localparam int unsigned SEQ_OFF = 1;
  localparam int unsigned SEQ_EXS = 2;
  localparam int unsigned SEQ_ENS = 3;
  localparam logic [7:0] ADDR_POWER_ON = 8'h1A;
  localparam logic [7:0] ADDR_POWER_OFF = 8'h1C;
  localparam logic [7:0] ADDR_SLEEP_EXIT = 8'h1E;
  localparam logic [7:0] ADDR_SLEEP_ENTRY = 8'h20;
  localparam int unsigned FLAG_LSB = 0;
  localparam int unsigned FLAG_MSB = 5;
  localparam int unsigned RSVD_LSB = 6;
  localparam int unsigned RSVD_MSB = 7;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [1:0] RSVD_VALUE = 2'h0;
  localparam logic [3:0] CHECK_NONE = 4'h0;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_RUN_ON = 3'b001,
    SEQ_RUN_OFF = 3'b010,
    SEQ_RUN_EXS = 3'b011,
    SEQ_RUN_ENS = 3'b100
  } seq_state_e;
endpackage
`default_nettype wire

// ### rtl/sequence_fault_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
module sequence_fault_status_bank #(
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Sequence control
  input wire logic run_request_pin,
  input wire logic sleep_request_pin,
  input wire logic sequence_done,
  // Recorded and expected counters, channel 1 at index 0
  input wire logic [5:0][CNT_W-1:0] power_on_recorded_count,
  input wire logic [5:0][CNT_W-1:0] power_on_expected_count,
  input wire logic [5:0][CNT_W-1:0] power_off_recorded_count,
  input wire logic [5:0][CNT_W-1:0] power_off_expected_count,
  input wire logic [5:0][CNT_W-1:0] sleep_exit_recorded_count,
  input wire logic [5:0][CNT_W-1:0] sleep_exit_expected_count,
  input wire logic [5:0][CNT_W-1:0] sleep_entry_recorded_count,
  input wire logic [5:0][CNT_W-1:0] sleep_entry_expected_count,
  // Per-channel enables
  input wire logic [5:0] power_on_fault_enable,
  input wire logic [5:0] power_off_fault_enable,
  input wire logic [5:0] sleep_exit_fault_enable,
  input wire logic [5:0] sleep_entry_fault_enable,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // Flag outputs
  output logic [5:0] power_on_fault_flag,
  output logic [5:0] power_off_fault_flag,
  output logic [5:0] sleep_exit_fault_flag,
  output logic [5:0] sleep_entry_fault_flag
);
  localparam int unsigned NCH = seq_fault_pkg::NUM_CH;
  localparam int unsigned NSQ = seq_fault_pkg::NUM_SEQ;

  seq_check_if chk ();

  logic [NSQ-1:0][NCH-1:0] flags_q, flags_d;
  logic [NSQ-1:0][NCH-1:0] set_v;
  logic [NSQ-1:0][NCH-1:0] clr_v;
  logic [NSQ-1:0] hit;
  logic [7:0] rdata_q, rdata_d;

  // Per-channel compare, gated by the channel enable
  function automatic logic [5:0] mismatch(
    input logic [5:0][CNT_W-1:0] rec,
    input logic [5:0][CNT_W-1:0] expv,
    input logic [5:0] en
  );
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++) begin
      m[i] = (rec[i] != expv[i]) && en[i];
    end
    return m;
  endfunction

  function automatic logic [3:0] reg_hit(input logic [7:0] a);
    logic [3:0] h;
    h = 4'h0;
    h[seq_fault_pkg::SEQ_ON] = (a == seq_fault_pkg::ADDR_POWER_ON);
    h[seq_fault_pkg::SEQ_OFF] = (a == seq_fault_pkg::ADDR_POWER_OFF);
    h[seq_fault_pkg::SEQ_EXS] = (a == seq_fault_pkg::ADDR_SLEEP_EXIT);
    h[seq_fault_pkg::SEQ_ENS] = (a == seq_fault_pkg::ADDR_SLEEP_ENTRY);
    return h;
  endfunction

  sequence_tracker u_tracker (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .run_request_pin(run_request_pin),
    .sleep_request_pin(sleep_request_pin),
    .sequence_done(sequence_done),
    .chk(chk.src)
  );

  always_comb begin
    hit = reg_hit(reg_addr);
    set_v[seq_fault_pkg::SEQ_ON] = mismatch(power_on_recorded_count,
      power_on_expected_count, power_on_fault_enable)
      & {NCH{chk.check[seq_fault_pkg::SEQ_ON]}};
    set_v[seq_fault_pkg::SEQ_OFF] = mismatch(power_off_recorded_count,
      power_off_expected_count, power_off_fault_enable)
      & {NCH{chk.check[seq_fault_pkg::SEQ_OFF]}};
    set_v[seq_fault_pkg::SEQ_EXS] = mismatch(sleep_exit_recorded_count,
      sleep_exit_expected_count, sleep_exit_fault_enable)
      & {NCH{chk.check[seq_fault_pkg::SEQ_EXS]}};
    set_v[seq_fault_pkg::SEQ_ENS] = mismatch(sleep_entry_recorded_count,
      sleep_entry_expected_count, sleep_entry_fault_enable)
      & {NCH{chk.check[seq_fault_pkg::SEQ_ENS]}};
    flags_d = flags_q;
    rdata_d = rdata_q;
    for (int k = 0; k < NSQ; k++) begin
      // Reserved write bits are simply dropped
      clr_v[k] = (reg_wr_en && hit[k])
        ? reg_wr_data[seq_fault_pkg::FLAG_MSB:seq_fault_pkg::FLAG_LSB]
        : seq_fault_pkg::FLAGS_RESET;
      if (ce) begin
        // Set beats a same-cycle clear so no fault is lost
        flags_d[k] = (flags_q[k] & ~clr_v[k]) | set_v[k];
      end
    end
    if (ce && reg_rd_en) begin
      rdata_d = seq_fault_pkg::RDATA_RESET;
      for (int k = 0; k < NSQ; k++) begin
        if (hit[k]) begin
          rdata_d = {seq_fault_pkg::RSVD_VALUE, flags_q[k]};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= {NSQ{seq_fault_pkg::FLAGS_RESET}};
      rdata_q <= seq_fault_pkg::RDATA_RESET;
    end else begin
      flags_q <= flags_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rd_data = rdata_q;
  assign power_on_fault_flag = flags_q[seq_fault_pkg::SEQ_ON];
  assign power_off_fault_flag = flags_q[seq_fault_pkg::SEQ_OFF];
  assign sleep_exit_fault_flag = flags_q[seq_fault_pkg::SEQ_EXS];
  assign sleep_entry_fault_flag = flags_q[seq_fault_pkg::SEQ_ENS];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_ON_SET: assert property (
    ce && chk.check[0] && power_on_fault_enable[0]
    && power_on_recorded_count[0] != power_on_expected_count[0]
    |=> power_on_fault_flag[0])
    else $error("power-on mismatch did not set flag");
  AST_OFF_SET: assert property (
    ce && chk.check[1] && power_off_fault_enable[5]
    && power_off_recorded_count[5] != power_off_expected_count[5]
    |=> power_off_fault_flag[5])
    else $error("power-off mismatch did not set flag");
  AST_EXS_SET: assert property (
    ce && chk.check[2] && sleep_exit_fault_enable[2]
    && sleep_exit_recorded_count[2] != sleep_exit_expected_count[2]
    |=> sleep_exit_fault_flag[2])
    else $error("sleep-exit mismatch did not set flag");
  AST_ENS_SET: assert property (
    ce && chk.check[3] && sleep_entry_fault_enable[3]
    && sleep_entry_recorded_count[3] != sleep_entry_expected_count[3]
    |=> sleep_entry_fault_flag[3])
    else $error("sleep-entry mismatch did not set flag");
  AST_STICKY: assert property (
    power_on_fault_flag[1] && !(reg_wr_en && reg_addr == 8'h1A && reg_wr_data[1])
    |=> power_on_fault_flag[1])
    else $error("flag dropped without a host clear");
  AST_W1C: assert property (
    ce && reg_wr_en && reg_addr == 8'h1C && reg_wr_data[4] && !chk.check[1]
    |=> !power_off_fault_flag[4])
    else $error("write one did not clear the flag");
  AST_W0_KEEP: assert property (
    ce && reg_wr_en && reg_addr == 8'h1E && !reg_wr_data[0] && sleep_exit_fault_flag[0]
    |=> sleep_exit_fault_flag[0])
    else $error("write zero changed the flag");
  AST_DISABLED_ZERO: assert property (
    !power_on_fault_flag[2] && !power_on_fault_enable[2]
    |=> !power_on_fault_flag[2])
    else $error("disabled channel raised a flag");
  AST_RSVD_ZERO: assert property (
    reg_rd_data[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  AST_READ_MAP: assert property (
    ce && reg_rd_en && reg_addr == 8'h20
    |=> reg_rd_data[5:0] == $past(sleep_entry_fault_flag))
    else $error("read data does not match flags");
  AST_ON_SET_CH6: assert property (
    ce && chk.check[0] && power_on_fault_enable[5]
    && power_on_recorded_count[5] != power_on_expected_count[5]
    |=> power_on_fault_flag[5])
    else $error("power-on mismatch on channel six did not set flag");
  AST_OFF_SET_CH1: assert property (
    ce && chk.check[1] && power_off_fault_enable[0]
    && power_off_recorded_count[0] != power_off_expected_count[0]
    |=> power_off_fault_flag[0])
    else $error("power-off mismatch on channel one did not set flag");
  AST_EXS_SET_CH5: assert property (
    ce && chk.check[2] && sleep_exit_fault_enable[4]
    && sleep_exit_recorded_count[4] != sleep_exit_expected_count[4]
    |=> sleep_exit_fault_flag[4])
    else $error("sleep-exit mismatch on channel five did not set flag");
  AST_ENS_SET_CH1: assert property (
    ce && chk.check[3] && sleep_entry_fault_enable[0]
    && sleep_entry_recorded_count[0] != sleep_entry_expected_count[0]
    |=> sleep_entry_fault_flag[0])
    else $error("sleep-entry mismatch on channel one did not set flag");
  // Flags may only rise at the end of a tracked sequence
  AST_OFF_ONLY_ON_DONE: assert property (
    !power_off_fault_flag[3] && !(ce && sequence_done)
    |=> !power_off_fault_flag[3])
    else $error("power-off flag rose outside a sequence end");
  // Low enable must hold every flag and the read data
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(flags_q) && $stable(reg_rd_data))
    else $error("state moved while clock enable was low");
  AST_UNMAPPED_READ: assert property (
    ce && reg_rd_en && reg_addr == 8'h1B
    |=> reg_rd_data == 8'h00)
    else $error("unmapped read returned nonzero");
  AST_RD_HOLD: assert property (
    !(ce && reg_rd_en) |=> $stable(reg_rd_data))
    else $error("read data changed without a read");
  AST_W1C_ON: assert property (
    ce && reg_wr_en && reg_addr == 8'h1A && reg_wr_data[2] && !sequence_done
    |=> !power_on_fault_flag[2])
    else $error("write one did not clear the power-on flag");

  COV_ON_FAULT: cover property (ce && chk.check[0] ##1 |power_on_fault_flag);
  COV_CLEAR: cover property (|sleep_exit_fault_flag ##1 reg_wr_en ##1 !(|sleep_exit_fault_flag));
  COV_SET_AND_CLEAR: cover property (ce && chk.check[3] && reg_wr_en && reg_addr == 8'h20);
  COV_REARM: cover property (
    |power_off_fault_flag ##1 !(|power_off_fault_flag) ##[1:60] |power_off_fault_flag);
  COV_CE_HOLD: cover property (!ce && reg_wr_en);
endmodule // sequence_fault_status_bank
`default_nettype wire

// ### rtl/sequence_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module sequence_tracker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Control pins
  input wire logic run_request_pin,
  input wire logic sleep_request_pin,
  input wire logic sequence_done,
  // Check strobes
  seq_check_if.src chk
);
  logic run_q, run_d;
  logic sleep_q, sleep_d;
  seq_fault_pkg::seq_state_e state_q, state_d;
  logic run_rise, run_fall, sleep_rise, sleep_fall;

  always_comb begin
    run_rise = run_request_pin && !run_q;
    run_fall = !run_request_pin && run_q;
    // Sleep edges only count while the rails are running
    sleep_rise = sleep_request_pin && !sleep_q && run_q && run_request_pin;
    sleep_fall = !sleep_request_pin && sleep_q && run_q && run_request_pin;
    run_d = run_q;
    sleep_d = sleep_q;
    state_d = state_q;
    chk.check = seq_fault_pkg::CHECK_NONE;
    if (ce) begin
      run_d = run_request_pin;
      sleep_d = sleep_request_pin;
      if (sequence_done) begin
        case (state_q)
          seq_fault_pkg::SEQ_RUN_ON: chk.check[seq_fault_pkg::SEQ_ON] = 1'b1;
          seq_fault_pkg::SEQ_RUN_OFF: chk.check[seq_fault_pkg::SEQ_OFF] = 1'b1;
          seq_fault_pkg::SEQ_RUN_EXS: chk.check[seq_fault_pkg::SEQ_EXS] = 1'b1;
          seq_fault_pkg::SEQ_RUN_ENS: chk.check[seq_fault_pkg::SEQ_ENS] = 1'b1;
          default: chk.check = seq_fault_pkg::CHECK_NONE;
        endcase
        state_d = seq_fault_pkg::SEQ_IDLE;
      end
      // A new edge restarts tracking even mid-sequence
      if (run_rise) begin
        state_d = seq_fault_pkg::SEQ_RUN_ON;
      end else if (run_fall) begin
        state_d = seq_fault_pkg::SEQ_RUN_OFF;
      end else if (sleep_rise) begin
        state_d = seq_fault_pkg::SEQ_RUN_EXS;
      end else if (sleep_fall) begin
        state_d = seq_fault_pkg::SEQ_RUN_ENS;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      sleep_q <= 1'b0;
      state_q <= seq_fault_pkg::SEQ_IDLE;
    end else begin
      run_q <= run_d;
      sleep_q <= sleep_d;
      state_q <= state_d;
    end
  end

  AST_RUN_RISE_ON: assert property (@(posedge clock) disable iff (!rst_n)
    ce && run_request_pin && !run_q |=> state_q == seq_fault_pkg::SEQ_RUN_ON)
    else $error("run rise did not start power-on tracking");
  AST_RUN_FALL_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !run_request_pin && run_q |=> state_q == seq_fault_pkg::SEQ_RUN_OFF)
    else $error("run fall did not start power-off tracking");
  AST_SLEEP_FALL_ENS: assert property (@(posedge clock) disable iff (!rst_n)
    ce && run_q && run_request_pin && sleep_q && !sleep_request_pin
    |=> state_q == seq_fault_pkg::SEQ_RUN_ENS)
    else $error("sleep fall did not start sleep-entry tracking");
endmodule // sequence_tracker
`default_nettype wire
